// ===== logic/pso_core.sv
// Program counter, status flags and option register behind AHB-Lite
//
// What this block does
// [R1] Add sets nibble carry on low-nibble carry
// [R2] Subtract sets nibble carry when no nibble borrow
// [R3] Option register is six bits, write-only
// [R4] Option-load instruction copies working register in
// [R5] Any reset sets all option bits
// [R6] Option bit 5 selects timer source
// [R7] Option bit 4 selects external edge
// [R8] Option bit 3 routes prescaler; smallest lacks watchdog
// [R9] Rate field gives timer or watchdog division
// [R10] Counter advances each cycle while running, and on each executed command, unless loaded
// [R11] Jump loads counter bits 8 to 0
// [R12] Low counter byte readable and writable
// [R13] Loads copy page bits into counter 9,10
// [R14] Call and low-byte writes clear bit 8
// [R15] Move, add, bit-set to low byte load counter
// [R16] Page overflow continues; page bits unchanged
// [R17] Software itself updates page bits
// [R18] Reset sets counter to all ones
// [R19] Reset clears page-select bits
// [R20] Two page bits select 512-word pages
// [R21] Flag results override writes to status
// [R22] Timeout, power-down read-only, reset to one
// [R23] Counter width 9 to 11; extra pages ignored
// [R24] Zero flag set on zero result
`timescale 1ns/1ps
`include "pso_map.svh"

module pso_core
  import pso_pkg::*;
#(
  parameter int PC_W    = 11,
  parameter bit HAS_WDT = 1'b1
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  input  wire logic            watchdog_timeout,
  output logic [PC_W-1:0]      pc_addr,
  output logic                 instruction_cycle_clock,
  output logic                 timer_source_select,
  output logic                 timer_edge_select,
  output logic                 prescaler_assign,
  output logic [2:0]           prescaler_rate,
  output logic [3:0]           timer_div_log2,
  output logic [2:0]           watchdog_div_log2
);

  ////////////////////////////////////////////////////////////////////////
  // Instruction cycle divider

  logic [1:0] cyc_cnt_reg;
  logic       tick;
  logic       icc_reg;

  assign tick = (cyc_cnt_reg == `PSO_CYC_DIV);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_cnt_reg <= 2'h0;
    end else if (tick) begin
      cyc_cnt_reg <= 2'h0;
    end else begin
      cyc_cnt_reg <= cyc_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      icc_reg <= 1'b0;
    end else begin
      icc_reg <= cyc_cnt_reg[1];
    end
  end

  assign instruction_cycle_clock = icc_reg;

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  pso_bus_t   bus_reg;
  pso_bus_t   bus_next;
  logic [3:0] idx_reg;
  logic       accept;
  logic       wr_en;

  assign accept    = hsel && hready && htrans[1];
  assign wr_en     = (bus_reg == PSO_BS_WDATA);
  assign hreadyout = (bus_reg != PSO_BS_RWAIT);
  assign hresp     = 1'b0;

  always_comb begin
    bus_next = PSO_BS_IDLE;
    unique case (bus_reg)
      PSO_BS_RWAIT: bus_next = PSO_BS_RDONE;
      PSO_BS_IDLE, PSO_BS_RDONE, PSO_BS_WDATA: begin
        if (accept) begin
          bus_next = hwrite ? PSO_BS_WDATA : PSO_BS_RWAIT;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reg <= PSO_BS_IDLE;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // Addresses outside the word map fall on an index past the table
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_reg <= 4'hf;
    end else if (accept) begin
      idx_reg <= (haddr[31:6] == 26'h0) ? haddr[5:2] : 4'hf;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers

  logic [7:0]  w_reg;
  logic        run_reg;
  logic        pend_reg;
  logic [24:0] cmd_reg;
  logic [7:0]  res_reg;
  logic        exec;

  assign exec = tick && pend_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 1'b0;
    end else if (wr_en && idx_reg == `PSO_IDX_CTRL) begin
      run_reg <= hwdata[`PSO_CTRL_RUN];
    end
  end

  // A command written while one waits is dropped; busy shows it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= 1'b0;
      cmd_reg  <= 25'h0;
    end else if (wr_en && idx_reg == `PSO_IDX_CMD && !pend_reg) begin
      pend_reg <= 1'b1;
      cmd_reg  <= hwdata[24:0];
    end else if (exec) begin
      pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Execution datapath

  pso_op_t    op;
  logic [7:0] val;
  logic [8:0] tgt;
  logic       to_status;
  logic [7:0] counter_low_byte;

  logic [7:0] st_pa_f;
  logic       st_to;
  logic       st_pd;
  logic       st_z;
  logic       st_dc;
  logic       st_c;
  logic [2:0] st_pa;

  logic [7:0] res;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic       arith;
  logic       zflag;
  logic       wr_res;

  always_comb begin
    unique case (cmd_reg[`PSO_CMD_OP_HI:0])
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
      4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc:
        op = pso_op_t'(cmd_reg[`PSO_CMD_OP_HI:0]);
      default: op = PSO_OP_NOP;
    endcase
  end

  assign val       = cmd_reg[`PSO_CMD_VAL_HI:`PSO_CMD_VAL_LO];
  assign tgt       = cmd_reg[`PSO_CMD_TGT_HI:`PSO_CMD_TGT_LO];
  assign to_status = cmd_reg[`PSO_CMD_DEST];
  assign counter_low_byte       = pc_addr[7:0];

  always_comb begin
    res    = w_reg;
    sum9   = 9'h000;
    nib5   = 5'h00;
    arith  = 1'b0;
    zflag  = 1'b0;
    wr_res = 1'b0;
    unique case (op)
      PSO_OP_ADD, PSO_OP_ADD_PCL: begin
        sum9  = {1'b0, (op == PSO_OP_ADD) ? val : counter_low_byte} + {1'b0, w_reg};
        nib5  = {1'b0, (op == PSO_OP_ADD) ? val[3:0] : counter_low_byte[3:0]}
              + {1'b0, w_reg[3:0]}; // [R1]
        res   = sum9[7:0];
        arith = 1'b1;
        zflag = 1'b1;
        wr_res = (op == PSO_OP_ADD);
      end
      PSO_OP_SUB: begin
        // Carry and nibble carry act as inverted borrows
        sum9  = {1'b0, val} + {1'b0, ~w_reg} + 9'h001;
        nib5  = {1'b0, val[3:0]} + {1'b0, ~w_reg[3:0]} + 5'h01; // [R2]
        res   = sum9[7:0];
        arith = 1'b1;
        zflag = 1'b1;
        wr_res = 1'b1;
      end
      PSO_OP_AND: begin
        res    = val & w_reg;
        zflag  = 1'b1;
        wr_res = 1'b1;
      end
      PSO_OP_MOV: begin
        res    = w_reg;
        wr_res = 1'b1;
      end
      PSO_OP_BSF_PCL: res = counter_low_byte | (8'h01 << val[2:0]); // [R15]
      PSO_OP_MOV_PCL: res = w_reg; // [R15]
      default: res = w_reg;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_reg <= 8'h00;
    end else if (exec) begin
      res_reg <= res;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_reg <= 8'h00;
    end else if (exec && wr_res && !to_status) begin
      w_reg <= res;
    end else if (wr_en && idx_reg == `PSO_IDX_WREG) begin
      w_reg <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags

  logic st_wr_bus;
  logic st_wr_ins;

  assign st_wr_bus = wr_en && idx_reg == `PSO_IDX_STATUS;
  assign st_wr_ins = exec && wr_res && to_status;

  // Computed flags win over the data written to them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_z  <= 1'b0;
      st_dc <= 1'b0;
      st_c  <= 1'b0;
    end else if (exec && (arith || zflag)) begin
      st_z <= (res == 8'h00); // [R24] [R21]
      if (arith) begin
        st_dc <= nib5[4]; // [R1] [R2]
        st_c  <= sum9[8];
      end
    end else if (st_wr_ins || st_wr_bus) begin
      st_z  <= st_wr_ins ? res[`PSO_ST_Z]  : hwdata[`PSO_ST_Z];
      st_dc <= st_wr_ins ? res[`PSO_ST_DC] : hwdata[`PSO_ST_DC];
      st_c  <= st_wr_ins ? res[`PSO_ST_C]  : hwdata[`PSO_ST_C];
    end
  end

  // Page bits change only by explicit writes, never by the counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_pa <= 3'h0; // [R19]
    end else if (st_wr_ins) begin
      st_pa <= res[`PSO_ST_PA_HI:`PSO_ST_PA_LO]; // [R16]
    end else if (st_wr_bus) begin
      st_pa <= hwdata[`PSO_ST_PA_HI:`PSO_ST_PA_LO];
    end
  end

  // Timeout and power-down are hardware-owned; no write reaches them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_to <= `PSO_FLAG_RST; // [R22]
      st_pd <= `PSO_FLAG_RST; // [R22]
    end else if (watchdog_timeout) begin
      st_to <= 1'b0;
    end else if (exec && op == PSO_OP_CLRWDT) begin
      st_to <= 1'b1;
      st_pd <= 1'b1;
    end else if (exec && op == PSO_OP_SLEEP) begin
      st_to <= 1'b1;
      st_pd <= 1'b0;
    end
  end

  assign st_pa_f = {st_pa, st_to, st_pd, st_z, st_dc, st_c};

  ////////////////////////////////////////////////////////////////////////
  // Option register

  logic [5:0] opt_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_reg <= `PSO_OPT_RST; // [R5]
    end else if (exec && op == PSO_OP_OPTION) begin
      opt_reg <= w_reg[5:0]; // [R4]
    end
  end

  assign timer_source_select = opt_reg[`PSO_OPT_SRC];  // [R6]
  assign timer_edge_select   = opt_reg[`PSO_OPT_EDGE]; // [R7]
  // Without a watchdog path the prescaler stays on the timer
  assign prescaler_assign = HAS_WDT && opt_reg[`PSO_OPT_ASSIGN]; // [R8]
  assign prescaler_rate   = opt_reg[`PSO_OPT_RATE_HI:0];
  assign timer_div_log2   = {1'b0, prescaler_rate} + 4'h1; // [R9]
  assign watchdog_div_log2 = prescaler_rate; // [R9]

  ////////////////////////////////////////////////////////////////////////
  // Program counter

  logic [10:0]     ld11;
  logic [PC_W-1:0] pc_reg;
  logic            pc_load;

  // Page bits above the counter width fall off in the slice
  always_comb begin
    ld11    = {st_pa[1:0], 1'b0, res}; // [R13] [R14] [R20]
    pc_load = 1'b1;
    unique case (op)
      PSO_OP_GOTO: ld11 = {st_pa[1:0], tgt}; // [R11] [R13]
      PSO_OP_CALL: ld11 = {st_pa[1:0], 1'b0, val}; // [R14]
      PSO_OP_MOV_PCL, PSO_OP_ADD_PCL, PSO_OP_BSF_PCL:
        ld11 = {st_pa[1:0], 1'b0, res}; // [R15] [R14]
      default: pc_load = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_reg <= '1; // [R18]
    end else if (exec && pc_load) begin
      pc_reg <= ld11[PC_W-1:0]; // [R23]
    end else if (exec || (tick && run_reg)) begin
      pc_reg <= pc_reg + 1'b1; // [R10] [R16]
    end
  end

  assign pc_addr = pc_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (bus_reg == PSO_BS_RWAIT) begin
      hrdata <= 32'h0;
      unique case (idx_reg)
        `PSO_IDX_WREG:   hrdata[7:0] <= w_reg;
        `PSO_IDX_PC:     hrdata[PC_W-1:0] <= pc_reg; // [R12]
        `PSO_IDX_STATUS: hrdata[7:0] <= st_pa_f;
        `PSO_IDX_CTRL:   hrdata[1:0] <= {pend_reg, run_reg};
        `PSO_IDX_RESULT: hrdata[7:0] <= res_reg;
        default:         hrdata <= 32'h0; // [R3]
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic [10:0] pc_ext;
  logic [1:0]  page_mask;

  assign pc_ext    = 11'(pc_reg);
  assign page_mask = (PC_W > 10) ? 2'h3 : ((PC_W > 9) ? 2'h1 : 2'h0);

  a_pc_advance: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
    tick && !pend_reg && run_reg |=> pc_reg == $past(pc_reg) + 1'b1)
    else $error("counter did not advance");

  a_goto_load: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
    exec && op == PSO_OP_GOTO |=> pc_ext[8:0] == $past(tgt))
    else $error("jump target not loaded");

  a_call_clear8: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
    exec && op == PSO_OP_CALL |=> pc_ext[7:0] == $past(val) && !pc_ext[8])
    else $error("call load wrong");

  a_page_copy: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    exec && pc_load |=> pc_ext[10:9] == ($past(st_pa[1:0]) & page_mask))
    else $error("page bits not copied");

  a_page_wrap: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    tick && !pend_reg && run_reg && pc_ext[8:0] == 9'h1ff
    |=> pc_ext[8:0] == 9'h000 && $stable(st_pa))
    else $error("page overflow wrong");

  a_nib_add: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
    exec && op == PSO_OP_ADD
    |=> st_dc == ($past(5'(val[3:0]) + 5'(w_reg[3:0])) > 5'h0f))
    else $error("add nibble carry wrong");

  a_nib_sub: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
    exec && op == PSO_OP_SUB |=> st_dc == $past(val[3:0] >= w_reg[3:0]))
    else $error("subtract nibble borrow wrong");

  a_option_load: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
    exec && op == PSO_OP_OPTION |=> opt_reg == $past(w_reg[5:0]))
    else $error("option not loaded");

  a_zero_flag: assert property (@(posedge hclk) disable iff (!hresetn) // [R24]
    exec && zflag |=> st_z == (res_reg == 8'h00))
    else $error("zero flag wrong");

  a_option_hidden: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
    bus_reg == PSO_BS_RWAIT && idx_reg == `PSO_IDX_OPTION |=> hrdata == 32'h0)
    else $error("option readable");

  c_goto: cover property (@(posedge hclk) disable iff (!hresetn)
    exec && op == PSO_OP_GOTO);
  c_pcl_add: cover property (@(posedge hclk) disable iff (!hresetn)
    exec && op == PSO_OP_ADD_PCL);
  c_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
    tick && run_reg && pc_ext[8:0] == 9'h1ff);
  c_read: cover property (@(posedge hclk) disable iff (!hresetn)
    bus_reg == PSO_BS_RDONE && idx_reg == `PSO_IDX_STATUS);

endmodule : pso_core

// ===== logic/pso_map.svh
// Register indices, field positions, reset values and timing counts
`ifndef PSO_MAP_SVH
`define PSO_MAP_SVH

// Register indices; byte address is four times the index
`define PSO_IDX_CMD     4'h0
`define PSO_IDX_WREG    4'h1
`define PSO_IDX_PC      4'h2
`define PSO_IDX_STATUS  4'h3
`define PSO_IDX_CTRL    4'h4
`define PSO_IDX_RESULT  4'h5
`define PSO_IDX_OPTION  4'h6

// Status fields
`define PSO_ST_C        0
`define PSO_ST_DC       1
`define PSO_ST_Z        2
`define PSO_ST_PD       3
`define PSO_ST_TO       4
`define PSO_ST_PA_LO    5
`define PSO_ST_PA_HI    7

// Option fields
`define PSO_OPT_SRC     5
`define PSO_OPT_EDGE    4
`define PSO_OPT_ASSIGN  3
`define PSO_OPT_RATE_HI 2

// Command word fields
`define PSO_CMD_OP_HI   3
`define PSO_CMD_DEST    4
`define PSO_CMD_VAL_LO  8
`define PSO_CMD_VAL_HI  15
`define PSO_CMD_TGT_LO  16
`define PSO_CMD_TGT_HI  24

// Control fields
`define PSO_CTRL_RUN    0
`define PSO_CTRL_BUSY   1

// Reset values
`define PSO_OPT_RST     6'h3f
`define PSO_FLAG_RST    1'b1

// Last divider count; an instruction cycle is four clocks
`define PSO_CYC_DIV     2'h3

`endif

// ===== logic/pso_pkg.sv
// Types shared by the sequencing core
package pso_pkg;

  typedef enum logic [3:0] {
    PSO_OP_NOP     = 4'h0,
    PSO_OP_GOTO    = 4'h1,
    PSO_OP_CALL    = 4'h2,
    PSO_OP_MOV     = 4'h3,
    PSO_OP_ADD     = 4'h4,
    PSO_OP_SUB     = 4'h5,
    PSO_OP_AND     = 4'h6,
    PSO_OP_MOV_PCL = 4'h7,
    PSO_OP_ADD_PCL = 4'h8,
    PSO_OP_BSF_PCL = 4'h9,
    PSO_OP_OPTION  = 4'ha,
    PSO_OP_CLRWDT  = 4'hb,
    PSO_OP_SLEEP   = 4'hc
  } pso_op_t;

  typedef enum logic [3:0] {
    PSO_BS_IDLE  = 4'b0001,
    PSO_BS_RWAIT = 4'b0010,
    PSO_BS_RDONE = 4'b0100,
    PSO_BS_WDATA = 4'b1000
  } pso_bus_t;

endpackage : pso_pkg

// ===== verification/pso_core_bench.sv
// Self-checking bench for the sequencing core over its register bus
`timescale 1ns/1ps
`include "pso_map.svh"

module pc_status_option_core_bench
  import pso_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        watchdog_timeout;
  logic [10:0] pc_addr;
  logic        instruction_cycle_clock;
  logic        timer_source_select;
  logic        timer_edge_select;
  logic        prescaler_assign;
  logic [2:0]  prescaler_rate;
  logic [3:0]  timer_div_log2;
  logic [2:0]  watchdog_div_log2;
  int          miscompares;
  int          checked;

  pso_core #(.PC_W(11), .HAS_WDT(1'b1)) i_pso_core (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .hsel                    (hsel),
    .haddr                   (haddr),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hsize                   (hsize),
    .hwdata                  (hwdata),
    .hready                  (hreadyout),
    .hreadyout               (hreadyout),
    .hresp                   (hresp),
    .hrdata                  (hrdata),
    .watchdog_timeout        (watchdog_timeout),
    .pc_addr                 (pc_addr),
    .instruction_cycle_clock (instruction_cycle_clock),
    .timer_source_select     (timer_source_select),
    .timer_edge_select       (timer_edge_select),
    .prescaler_assign        (prescaler_assign),
    .prescaler_rate          (prescaler_rate),
    .timer_div_log2          (timer_div_log2),
    .watchdog_div_log2       (watchdog_div_log2)
  );

  always #5 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  // Every wait is bounded; a hung bus ends the run
  // Ready is taken mid-cycle, as the slave sees it at the coming edge
  task automatic wait_rdy();
    int   n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      @(posedge hclk);
      n++;
    end while (rdy !== 1'b1 && n < 40);
    if (rdy !== 1'b1) begin
      $display("unexpected at %0t: got %h expected %h", $time, rdy, 1'b1);
      miscompares++;
      finish_test();
    end
  endtask : wait_rdy

  // Entered just after a rising edge; read data taken at the last edge
  task automatic bus(input logic wr, input logic [3:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {26'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr_reg(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    chk(r, exp);
  endtask : rd_chk

  // Issue one command and poll busy until it has executed
  task automatic exec(input pso_op_t op, input logic dest,
                      input logic [7:0] f, input logic [8:0] tgt);
    logic [31:0] r;
    int          n;
    wr_reg(`PSO_IDX_CMD, {7'h0, tgt, f, 3'b000, dest, op});
    n = 0;
    do begin
      bus(1'b0, `PSO_IDX_CTRL, 32'h0, r);
      n++;
    end while (r[`PSO_CTRL_BUSY] !== 1'b0 && n < 10);
    if (r[`PSO_CTRL_BUSY] !== 1'b0) begin
      $display("unexpected at %0t: got %h expected %h", $time, r, 32'h0);
      miscompares++;
      finish_test();
    end
  endtask : exec

  // Result, zero, nibble carry, carry; subtract flags are no-borrow
  function automatic logic [10:0] alu(input logic sub,
                                      input logic [7:0] f,
                                      input logic [7:0] w);
    logic [8:0] s;
    logic       dc;
    logic       c;
    if (sub) begin
      s  = {1'b0, f} - {1'b0, w};
      dc = f[3:0] >= w[3:0];
      c  = f >= w;
    end else begin
      s  = {1'b0, f} + {1'b0, w};
      dc = ({1'b0, f[3:0]} + {1'b0, w[3:0]}) > 5'h0f;
      c  = s[8];
    end
    return {s[7:0], s[7:0] == 8'h00, dc, c};
  endfunction : alu

  task automatic check_reset();
    chk(pc_addr, 32'h7ff);
    chk({timer_source_select, timer_edge_select, prescaler_assign,
         prescaler_rate}, 32'h3f);
    chk({timer_div_log2, watchdog_div_log2}, {25'h0, 4'h8, 3'h7});
    rd_chk(`PSO_IDX_STATUS, 32'h18);
    rd_chk(`PSO_IDX_OPTION, 32'h0);
    rd_chk(4'hf, 32'h0);
  endtask : check_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rnd;
    logic [7:0]  f;
    logic [7:0]  w;
    logic [1:0]  pa;
    logic [8:0]  t;
    logic [10:0] x;
    logic [10:0] pc;
    int          n;
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    watchdog_timeout = 1'b0;
    miscompares = 0;
    checked = 0;
    void'($urandom(77409));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_reset();
    // Option load: every rate code, random upper fields
    for (int i = 0; i < 8; i++) begin
      rnd = $urandom;
      w = {rnd[7:3], i[2:0]};
      wr_reg(`PSO_IDX_WREG, {24'h0, w});
      exec(PSO_OP_OPTION, 1'b0, 8'h00, 9'h0);
      chk({timer_source_select, timer_edge_select, prescaler_assign,
           prescaler_rate}, {26'h0, w[5:0]});
      chk(timer_div_log2, {28'h0, 1'b0, w[2:0]} + 32'h1);
      chk(watchdog_div_log2, {29'h0, w[2:0]});
      rd_chk(`PSO_IDX_OPTION, 32'h0);
    end
    // Add and subtract with nibble-boundary corners first
    for (int i = 0; i < 12; i++) begin
      rnd = $urandom;
      f = rnd[7:0];
      w = rnd[15:8];
      if (i == 0) begin f = 8'h0f; w = 8'h01; end
      if (i == 1) begin f = 8'h10; w = 8'h01; end
      if (i == 2) begin f = 8'h5a; w = 8'h5a; end
      wr_reg(`PSO_IDX_WREG, {24'h0, w});
      exec(i[0] ? PSO_OP_SUB : PSO_OP_ADD, 1'b0, f, 9'h0);
      x = alu(i[0], f, w);
      rd_chk(`PSO_IDX_WREG, {24'h0, x[10:3]});
      rd_chk(`PSO_IDX_STATUS, {27'h3, x[2:0]});
    end
    // Flag op into status: written flags lose, result bits give page
    wr_reg(`PSO_IDX_STATUS, 32'h07);
    wr_reg(`PSO_IDX_WREG, 32'h40);
    exec(PSO_OP_ADD, 1'b1, 8'ha1, 9'h0);
    rd_chk(`PSO_IDX_STATUS, 32'hf8);
    // Jumps, calls and low-byte writes under random page bits
    for (int i = 0; i < 6; i++) begin
      rnd = $urandom;
      pa = (i == 0) ? 2'b11 : rnd[1:0];
      t = (i == 0) ? 9'h1ff : rnd[10:2];
      f = rnd[18:11];
      w = rnd[26:19];
      wr_reg(`PSO_IDX_STATUS, {25'h0, pa, 5'h00});
      exec(PSO_OP_GOTO, 1'b0, 8'h00, t);
      chk(pc_addr, {21'h0, pa, t});
      exec(PSO_OP_CALL, 1'b0, f, 9'h0);
      chk(pc_addr, {21'h0, pa, 1'b0, f});
      wr_reg(`PSO_IDX_WREG, {24'h0, w});
      exec(PSO_OP_MOV_PCL, 1'b0, 8'h00, 9'h0);
      chk(pc_addr, {21'h0, pa, 1'b0, w});
      exec(PSO_OP_ADD_PCL, 1'b0, 8'h00, 9'h0);
      w = w + w;
      chk(pc_addr, {21'h0, pa, 1'b0, w});
      exec(PSO_OP_BSF_PCL, 1'b0, f, 9'h0);
      w = w | (8'h01 << f[2:0]);
      chk(pc_addr, {21'h0, pa, 1'b0, w});
      rd_chk(`PSO_IDX_PC, {21'h0, pa, 1'b0, w});
    end
    // Increment across a page edge leaves page bits alone
    wr_reg(`PSO_IDX_STATUS, 32'h00);
    exec(PSO_OP_GOTO, 1'b0, 8'h00, 9'h1ff);
    exec(PSO_OP_NOP, 1'b0, 8'h00, 9'h0);
    chk(pc_addr, 32'h200);
    rd_chk(`PSO_IDX_STATUS, 32'h18);
    // Software has not moved the page, so the jump goes back to page 0
    exec(PSO_OP_GOTO, 1'b0, 8'h00, 9'h023);
    chk(pc_addr, 32'h023);
    // Free run: first step is exactly one
    pc = pc_addr;
    wr_reg(`PSO_IDX_CTRL, 32'h1);
    n = 0;
    while (pc_addr === 11'h023 && n < 12) begin
      @(posedge hclk);
      n++;
    end
    chk(pc_addr, 32'h024);
    wr_reg(`PSO_IDX_CTRL, 32'h0);
    // Timeout and power-down flags
    watchdog_timeout <= 1'b1;
    repeat (2) @(posedge hclk);
    watchdog_timeout <= 1'b0;
    rd_chk(`PSO_IDX_STATUS, 32'h08);
    wr_reg(`PSO_IDX_STATUS, 32'h18);
    rd_chk(`PSO_IDX_STATUS, 32'h08);
    exec(PSO_OP_SLEEP, 1'b0, 8'h00, 9'h0);
    rd_chk(`PSO_IDX_STATUS, 32'h10);
    exec(PSO_OP_CLRWDT, 1'b0, 8'h00, 9'h0);
    rd_chk(`PSO_IDX_STATUS, 32'h18);
    // Second reset in mid-run from a disturbed state
    wr_reg(`PSO_IDX_STATUS, 32'h40);
    wr_reg(`PSO_IDX_WREG, 32'h00);
    exec(PSO_OP_OPTION, 1'b0, 8'h00, 9'h0);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_reset();
    finish_test();
  end

endmodule : pc_status_option_core_bench
